// *** frl_pkg.sv ***
// Constants, types and register map of the flash row latch programmer.
// Assumes one APB clock at 25 MHz and an 8-bit APB byte address.
package frl_pkg;
	localparam int LATCH_COUNT = 32;
	localparam int WORD_W = 14;
	localparam int ROW_W = 10;
	localparam logic [WORD_W-1:0] BLANK_WORD = 14'h3fff;

	localparam logic [7:0] OFS_ADDR_LOW = 8'h00;
	localparam logic [7:0] OFS_ADDR_HIGH = 8'h04;
	localparam logic [7:0] OFS_WORD_LOW = 8'h08;
	localparam logic [7:0] OFS_WORD_HIGH = 8'h0c;
	localparam logic [7:0] OFS_CONTROL = 8'h10;
	localparam logic [7:0] OFS_UNLOCK_KEY = 8'h14;
	localparam logic [7:0] OFS_STATUS = 8'h18;

	localparam int CTRL_WR = 0;
	localparam int CTRL_WRITE_ENABLE_BIT = 1;
	localparam int CTRL_FAULT = 2;
	localparam int CTRL_ERASE = 3;
	localparam int CTRL_LATCH_ONLY = 4;
	localparam int CTRL_REGION = 6;
	localparam int STAT_DONE = 0;
	localparam int STAT_IRQ_EN = 1;

	localparam int ADDR_HIGH_W = 7;
	localparam int WORD_HIGH_W = 6;
	localparam logic [7:0] KEY_FIRST = 8'h55;
	localparam logic [7:0] KEY_SECOND = 8'haa;

	localparam int CLK_PERIOD_NS = 40;
	localparam int WORD_PROG_NS = 200;
	localparam int ROW_ERASE_NS = 2000;
	localparam int WORD_CYC = (WORD_PROG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ERASE_CYC = (ROW_ERASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TIMER_W = 12;

	typedef enum logic [2:0] {
		FRL_SEL_NONE, FRL_SEL_ADDR_LOW, FRL_SEL_ADDR_HIGH, FRL_SEL_WORD_LOW,
		FRL_SEL_WORD_HIGH, FRL_SEL_CONTROL, FRL_SEL_KEY, FRL_SEL_STATUS
	} frl_sel_t;

	typedef enum logic [1:0] {
		FRL_UNL_IDLE, FRL_UNL_FIRST, FRL_UNL_ARMED
	} frl_unlock_t;

	typedef enum logic [1:0] {
		FRL_OP_IDLE, FRL_OP_PROG, FRL_OP_ERASE, FRL_OP_FINISH
	} frl_op_t;
endpackage

// *** frl_latch_if.sv ***
// Interface between the sequencer and the write latch buffer.
// Assumes both ends run on the APB clock.
interface frl_latch_if #(parameter int IDX_W = 5, parameter int WORD_W = 14);
	logic wr;
	logic [IDX_W-1:0] wr_idx;
	logic [WORD_W-1:0] wr_data;
	logic clear;
	logic [IDX_W-1:0] rd_idx;
	logic [WORD_W-1:0] rd_data;
	modport ctrl (output wr, wr_idx, wr_data, clear, rd_idx, input rd_data);
	modport store (input wr, wr_idx, wr_data, clear, rd_idx, output rd_data);
endinterface

// *** frl_latch_buf.sv ***
// Write latch buffer: one row worth of words, blank after reset or clear.
// Assumes clear and write never need to act on the same edge together.
module frl_latch_buf
	import frl_pkg::*;
#(
	parameter int NUM_LATCHES = LATCH_COUNT
) (
	input wire logic pclk,
	input wire logic presetn,
	frl_latch_if.store lat
);
	logic [WORD_W-1:0] mem_r [NUM_LATCHES];

	// Clear beats a load, so a finished operation always leaves blanks
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < NUM_LATCHES; i++) begin
				mem_r[i] <= BLANK_WORD;
			end
		end else if (lat.clear) begin
			for (int i = 0; i < NUM_LATCHES; i++) begin
				mem_r[i] <= BLANK_WORD;
			end
		end else if (lat.wr) begin
			mem_r[lat.wr_idx] <= lat.wr_data;
		end
	end

	assign lat.rd_data = mem_r[lat.rd_idx];
endmodule

// *** frl_programmer.sv ***
// Program flash row-write sequencer with APB register access.
// Assumes a flash macro that takes one word per program pulse and a
// row per erase pulse, and a protection input valid for the current row.
module frl_programmer
	import frl_pkg::*;
#(
	parameter int NUM_LATCHES = LATCH_COUNT,
	parameter int WORD_CYC_P = WORD_CYC,
	parameter int ERASE_CYC_P = ERASE_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic flash_wp,
	output logic [ROW_W-1:0] flash_row,
	output logic [4:0] flash_col,
	output logic [WORD_W-1:0] flash_data,
	output logic flash_prog,
	output logic flash_erase,
	output logic mem_op_irq
);
	localparam int IDX_W = $clog2(NUM_LATCHES);

	// The row and column split of the address pair is fixed at 32 words
	generate
		if (NUM_LATCHES != LATCH_COUNT) begin : g_bad_latches
			$error("NUM_LATCHES must be 32");
		end
		if (WORD_CYC_P < 1 || WORD_CYC_P >= (1 << TIMER_W)) begin : g_bad_word
			$error("WORD_CYC_P out of range");
		end
		if (ERASE_CYC_P < 1 || ERASE_CYC_P >= (1 << TIMER_W)) begin : g_bad_erase
			$error("ERASE_CYC_P out of range");
		end
	endgenerate

	localparam logic [TIMER_W-1:0] WORD_LAST = TIMER_W'(WORD_CYC_P - 1);
	localparam logic [TIMER_W-1:0] ERASE_LAST = TIMER_W'(ERASE_CYC_P - 1);
	localparam logic [IDX_W-1:0] IDX_LAST = IDX_W'(NUM_LATCHES - 1);

	frl_latch_if #(.IDX_W(IDX_W), .WORD_W(WORD_W)) lat ();

	frl_latch_buf #(.NUM_LATCHES(NUM_LATCHES)) u_latches (
		.pclk(pclk),
		.presetn(presetn),
		.lat(lat)
	);

	function automatic frl_sel_t reg_sel(input logic [7:0] a);
		if (a == OFS_ADDR_LOW) begin
			return FRL_SEL_ADDR_LOW;
		end else if (a == OFS_ADDR_HIGH) begin
			return FRL_SEL_ADDR_HIGH;
		end else if (a == OFS_WORD_LOW) begin
			return FRL_SEL_WORD_LOW;
		end else if (a == OFS_WORD_HIGH) begin
			return FRL_SEL_WORD_HIGH;
		end else if (a == OFS_CONTROL) begin
			return FRL_SEL_CONTROL;
		end else if (a == OFS_UNLOCK_KEY) begin
			return FRL_SEL_KEY;
		end else if (a == OFS_STATUS) begin
			return FRL_SEL_STATUS;
		end else begin
			return FRL_SEL_NONE;
		end
	endfunction

	logic [7:0] addr_low_r;
	logic [ADDR_HIGH_W-1:0] addr_high_r;
	logic [7:0] word_low_r;
	logic [WORD_HIGH_W-1:0] word_high_r;
	logic wr_r;
	logic write_enable_bit_r;
	logic fault_r;
	logic erase_r;
	logic latch_only_r;
	logic region_r;
	logic done_r;
	logic irq_en_r;
	frl_unlock_t unl_r;
	frl_op_t op_r;
	logic [TIMER_W-1:0] timer_r;
	logic [IDX_W-1:0] idx_r;
	logic [ROW_W-1:0] row_r;
	logic [IDX_W-1:0] col_r;
	logic [WORD_W-1:0] data_r;
	logic prog_r;
	logic erase_pulse_r;
	logic [31:0] prdata_r;

	frl_sel_t wsel;
	logic wr_acc;
	logic idle;
	logic start_req;
	logic go;
	logic unlock_broken;
	logic go_erase;
	logic go_load;
	logic go_prog;
	logic hw_fault;
	logic op_done;
	logic [ROW_W-1:0] cur_row;
	logic [WORD_W-1:0] cur_word;

	assign wsel = reg_sel(paddr);
	assign wr_acc = psel && penable && pwrite;
	assign idle = (op_r == FRL_OP_IDLE);
	assign cur_row = {addr_high_r, addr_low_r[7:5]};
	assign cur_word = {word_high_r, word_low_r};

	// A write to the initiate bit while idle asks for an action
	assign start_req = wr_acc && (wsel == FRL_SEL_CONTROL) &&
		pwdata[CTRL_WR] && idle;
	// Only an armed sequence with writes enabled and program flash selected
	assign go = start_req && (unl_r == FRL_UNL_ARMED) && write_enable_bit_r &&
		!region_r;
	// Any other write while a sequence is open breaks it
	always_comb begin
		unlock_broken = 1'b0;
		if (wr_acc && unl_r != FRL_UNL_IDLE) begin
			if (unl_r == FRL_UNL_FIRST) begin
				unlock_broken = !(wsel == FRL_SEL_KEY &&
					pwdata[7:0] == KEY_SECOND);
			end else begin
				unlock_broken = !(wsel == FRL_SEL_CONTROL &&
					pwdata[CTRL_WR]);
			end
		end
	end

	assign go_erase = go && erase_r && !flash_wp;
	assign go_load = go && !erase_r && latch_only_r;
	assign go_prog = go && !erase_r && !latch_only_r && !flash_wp;
	assign hw_fault = unlock_broken ||
		(go && !(latch_only_r && !erase_r) && flash_wp);
	assign op_done = (op_r == FRL_OP_FINISH);

	// Unlock sequence tracker
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			unl_r <= FRL_UNL_IDLE;
		end else if (wr_acc) begin
			case (unl_r)
				FRL_UNL_IDLE: begin
					if (wsel == FRL_SEL_KEY && pwdata[7:0] == KEY_FIRST) begin
						unl_r <= FRL_UNL_FIRST;
					end
				end
				FRL_UNL_FIRST: begin
					unl_r <= unlock_broken ? FRL_UNL_IDLE : FRL_UNL_ARMED;
				end
				default: begin
					unl_r <= FRL_UNL_IDLE;
				end
			endcase
		end
	end

	// Address and data pair; frozen while the flash is busy
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			addr_low_r <= 8'h00;
			addr_high_r <= 7'h00;
			word_low_r <= 8'h00;
			word_high_r <= 6'h00;
		end else if (wr_acc && idle) begin
			if (wsel == FRL_SEL_ADDR_LOW) begin
				addr_low_r <= pwdata[7:0];
			end else if (wsel == FRL_SEL_ADDR_HIGH) begin
				addr_high_r <= pwdata[ADDR_HIGH_W-1:0];
			end else if (wsel == FRL_SEL_WORD_LOW) begin
				word_low_r <= pwdata[7:0];
			end else if (wsel == FRL_SEL_WORD_HIGH) begin
				word_high_r <= pwdata[WORD_HIGH_W-1:0];
			end
		end
	end

	// Mode bits; held during an operation so the action cannot change midway
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			write_enable_bit_r <= 1'b0;
			erase_r <= 1'b0;
			latch_only_r <= 1'b0;
			region_r <= 1'b0;
		end else if (wr_acc && idle && wsel == FRL_SEL_CONTROL) begin
			write_enable_bit_r <= pwdata[CTRL_WRITE_ENABLE_BIT];
			erase_r <= pwdata[CTRL_ERASE];
			latch_only_r <= pwdata[CTRL_LATCH_ONLY];
			region_r <= pwdata[CTRL_REGION];
		end
	end

	// Software may set the fault bit for test; a hardware set beats a clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fault_r <= 1'b0;
		end else if (hw_fault) begin
			fault_r <= 1'b1;
		end else if (wr_acc && wsel == FRL_SEL_CONTROL) begin
			fault_r <= pwdata[CTRL_FAULT];
		end
	end

	// Write-initiate: software can only set it, and only through a good start
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_r <= 1'b0;
		end else if (go_prog || go_erase) begin
			wr_r <= 1'b1;
		end else if (op_done) begin
			wr_r <= 1'b0;
		end
	end

	// Completion flag is cleared by writing zero; completion beats the clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done_r <= 1'b0;
			irq_en_r <= 1'b0;
		end else begin
			if (op_done) begin
				done_r <= 1'b1;
			end else if (wr_acc && wsel == FRL_SEL_STATUS) begin
				done_r <= done_r & pwdata[STAT_DONE];
			end
			if (wr_acc && wsel == FRL_SEL_STATUS) begin
				irq_en_r <= pwdata[STAT_IRQ_EN];
			end
		end
	end

	// Operation sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			op_r <= FRL_OP_IDLE;
			timer_r <= '0;
			idx_r <= '0;
			row_r <= '0;
		end else begin
			case (op_r)
				FRL_OP_IDLE: begin
					timer_r <= '0;
					idx_r <= '0;
					// Row is captured so later address writes cannot move it
					row_r <= cur_row;
					if (go_prog) begin
						op_r <= FRL_OP_PROG;
					end else if (go_erase) begin
						op_r <= FRL_OP_ERASE;
					end
				end
				FRL_OP_PROG: begin
					if (timer_r == WORD_LAST) begin
						timer_r <= '0;
						if (idx_r == IDX_LAST) begin
							op_r <= FRL_OP_FINISH;
						end else begin
							idx_r <= idx_r + 1'b1;
						end
					end else begin
						timer_r <= timer_r + 1'b1;
					end
				end
				FRL_OP_ERASE: begin
					if (timer_r == ERASE_LAST) begin
						op_r <= FRL_OP_FINISH;
					end else begin
						timer_r <= timer_r + 1'b1;
					end
				end
				default: begin
					op_r <= FRL_OP_IDLE;
				end
			endcase
		end
	end

	// Latch port: loads on a good load or program start (not erase), reads follow the word index
	always_comb begin
		lat.wr = go_load || go_prog;
		lat.wr_idx = addr_low_r[IDX_W-1:0];
		lat.wr_data = cur_word;
		lat.clear = op_done;
		lat.rd_idx = idx_r;
	end

	// Flash macro strobes; every word is written, blank ones included
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prog_r <= 1'b0;
			erase_pulse_r <= 1'b0;
			col_r <= '0;
			data_r <= BLANK_WORD;
		end else begin
			prog_r <= (op_r == FRL_OP_PROG) && (timer_r == '0);
			erase_pulse_r <= (op_r == FRL_OP_ERASE) && (timer_r == '0);
			if (op_r == FRL_OP_PROG && timer_r == '0) begin
				col_r <= idx_r;
				data_r <= lat.rd_data;
			end
		end
	end

	// Read data captured in the setup phase, ready in the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata_r <= 32'h0000_0000;
			if (wsel == FRL_SEL_ADDR_LOW) begin
				prdata_r[7:0] <= addr_low_r;
			end else if (wsel == FRL_SEL_ADDR_HIGH) begin
				prdata_r[ADDR_HIGH_W-1:0] <= addr_high_r;
			end else if (wsel == FRL_SEL_WORD_LOW) begin
				prdata_r[7:0] <= word_low_r;
			end else if (wsel == FRL_SEL_WORD_HIGH) begin
				prdata_r[WORD_HIGH_W-1:0] <= word_high_r;
			end else if (wsel == FRL_SEL_CONTROL) begin
				prdata_r[CTRL_WR] <= wr_r;
				prdata_r[CTRL_WRITE_ENABLE_BIT] <= write_enable_bit_r;
				prdata_r[CTRL_FAULT] <= fault_r;
				prdata_r[CTRL_ERASE] <= erase_r;
				prdata_r[CTRL_LATCH_ONLY] <= latch_only_r;
				prdata_r[CTRL_REGION] <= region_r;
			end else if (wsel == FRL_SEL_STATUS) begin
				prdata_r[STAT_DONE] <= done_r;
				prdata_r[STAT_IRQ_EN] <= irq_en_r;
			end
		end
	end

	// Zero wait states; unmapped addresses answer with an error
	assign pready = 1'b1;
	assign pslverr = psel && penable && (wsel == FRL_SEL_NONE);
	assign prdata = prdata_r;
	assign flash_row = row_r;
	assign flash_col = col_r;
	assign flash_data = data_r;
	assign flash_prog = prog_r;
	assign flash_erase = erase_pulse_r;
	assign mem_op_irq = done_r && irq_en_r;
endmodule

// *** frl_checker.sv ***
// Port checker for the flash row latch programmer.
// Assumes one clock domain and attachment by the bind at the foot.
module frl_checker
	import frl_pkg::*;
#(
	parameter int WORD_CYC_P = WORD_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic flash_wp,
	input wire logic [ROW_W-1:0] flash_row,
	input wire logic [4:0] flash_col,
	input wire logic [WORD_W-1:0] flash_data,
	input wire logic flash_prog,
	input wire logic flash_erase,
	input wire logic mem_op_irq
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// Next word of the same row, one word period later
	sequence s_next_word;
		##WORD_CYC_P flash_prog && flash_row == $past(flash_row, WORD_CYC_P)
			&& flash_col == $past(flash_col, WORD_CYC_P) + 5'h1;
	endsequence
	sequence s_quiet;
		(!flash_prog && !flash_erase) [*3];
	endsequence
	a_ready_high: assert property (pready) else $error("ready low");
	a_prog_pulse: assert property (flash_prog |=> !flash_prog)
		else $error("program pulse too long");
	a_word_step: assert property (
		flash_prog && flash_col != 5'h1f |-> s_next_word)
		else $error("word sequence broken");
	a_row_end: assert property (
		flash_prog && flash_col == 5'h1f |=> !flash_prog [*4])
		else $error("program past row end");
	a_erase_quiet: assert property (flash_erase |=> s_quiet)
		else $error("activity after erase pulse");
	a_no_auto_erase: assert property (flash_prog |-> !flash_erase)
		else $error("erase during programming");
	a_err_decode: assert property (psel && penable |->
		pslverr == (paddr > OFS_STATUS || paddr[1:0] != 2'h0))
		else $error("slave error decode wrong");
	a_key_reads_zero: assert property (psel && penable && !pwrite
		&& paddr == OFS_UNLOCK_KEY |-> prdata == 32'h0)
		else $error("unlock key readable");
	c_prog_done: cover property (flash_prog && flash_col == 5'h1f);
endmodule

bind frl_programmer frl_checker #(.WORD_CYC_P(WORD_CYC_P)) frl_checker_i (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .flash_wp(flash_wp),
	.flash_row(flash_row), .flash_col(flash_col), .flash_data(flash_data),
	.flash_prog(flash_prog), .flash_erase(flash_erase),
	.mem_op_irq(mem_op_irq));

// *** frl_flash_model.sv ***
// Behavioural program flash array behind the programmer.
// Assumes one word per program pulse and one row per erase pulse.
module frl_flash_model
	import frl_pkg::*;
(
	input wire logic pclk,
	input wire logic [ROW_W-1:0] flash_row,
	input wire logic [4:0] flash_col,
	input wire logic [WORD_W-1:0] flash_data,
	input wire logic flash_prog,
	input wire logic flash_erase
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [WORD_W-1:0] mem [1024][32];
	initial begin
		foreach (mem[r, c]) mem[r][c] = BLANK_WORD;
	end
	always @(posedge pclk) begin
		// Cells only lose ones, so a missed erase shows up as stale bits
		if (flash_prog) begin
			mem[flash_row][flash_col] <=
				mem[flash_row][flash_col] & flash_data;
		end
		if (flash_erase) begin
			for (int c = 0; c < 32; c++) begin
				mem[flash_row][c] <= BLANK_WORD;
			end
		end
	end
endmodule

// *** flash_row_latch_programmer_test.sv ***
// Self-checking bench: random latch loads, row programs, erase, faults.
// Assumes the flash model above and APB with zero wait states.
module flash_row_latch_programmer_test import frl_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic flash_wp = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, flash_prog, flash_erase, mem_op_irq, er;
	logic [ROW_W-1:0] flash_row, r0, row;
	logic [4:0] flash_col;
	logic [WORD_W-1:0] flash_data;
	logic [WORD_W-1:0] lat [32];
	logic [WORD_W-1:0] efl [1024][32];
	int errors = 0, n_tests = 0, cyc = 0;
	frl_programmer #(.WORD_CYC_P(2), .ERASE_CYC_P(4)) frl_programmer_i (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .flash_wp(flash_wp),
		.flash_row(flash_row), .flash_col(flash_col),
		.flash_data(flash_data), .flash_prog(flash_prog),
		.flash_erase(flash_erase), .mem_op_irq(mem_op_irq));
	frl_flash_model frl_flash_model_i (.pclk(pclk), .flash_row(flash_row),
		.flash_col(flash_col), .flash_data(flash_data),
		.flash_prog(flash_prog), .flash_erase(flash_erase));
	always #20 pclk = ~pclk;
	task end_of_test;
		if (errors == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// Generous ceiling: the whole sequence needs roughly two thousand cycles
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			errors++;
			end_of_test;
		end
	end
	task cmp(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Programming only clears bits, so a cell keeps what both words share
	function automatic logic [WORD_W-1:0] cell_after(
		input logic [WORD_W-1:0] old, input logic [WORD_W-1:0] nw);
		return old & nw;
	endfunction
	task rdc(input logic [7:0] a, input logic [31:0] e);
		apb(a, 1'b0, 32'h0);
		cmp(rd, e);
	endtask
	task unlock(input logic [31:0] c, input logic brk);
		apb(OFS_UNLOCK_KEY, 1'b1, 32'(KEY_FIRST));
		if (brk) begin
			apb(OFS_ADDR_HIGH, 1'b1, 32'(row[9:3]));
			rdc(OFS_CONTROL, 32'h16);
		end
		apb(OFS_UNLOCK_KEY, 1'b1, 32'(KEY_SECOND));
		apb(OFS_CONTROL, 1'b1, c);
	endtask
	task setup(input logic [4:0] i, input logic [13:0] d);
		apb(OFS_ADDR_HIGH, 1'b1, 32'(row[9:3]));
		apb(OFS_ADDR_LOW, 1'b1, 32'({row[2:0], i}));
		apb(OFS_WORD_LOW, 1'b1, 32'(d[7:0]));
		apb(OFS_WORD_HIGH, 1'b1, 32'(d[13:8]));
	endtask
	task chk_row;
		for (int k = 0; k < 32; k++) begin
			cmp(32'(frl_flash_model_i.mem[row][k]),
				32'(efl[row][k]));
		end
	endtask
	task finish_op(input logic [31:0] c);
		for (int k = 0; k < 2000 && mem_op_irq !== 1'b1; k++) @(posedge pclk);
		cmp(32'(mem_op_irq), 32'h1);
		rdc(OFS_STATUS, 32'h3);
		rdc(OFS_CONTROL, c);
		apb(OFS_STATUS, 1'b1, 32'h2);
		@(posedge pclk);
		cmp(32'(mem_op_irq), 32'h0);
		foreach (lat[k]) lat[k] = BLANK_WORD;
		chk_row;
	endtask
	task load(input int n, input logic brk);
		logic [4:0] i;
		logic [13:0] d;
		apb(OFS_CONTROL, 1'b1, 32'h12);
		repeat (n) begin
			i = 5'($urandom);
			d = 14'($urandom);
			setup(i, d);
			unlock(brk ? 32'h17 : 32'h13, brk);
			if (!brk) lat[i] = d;
		end
		if (brk) rdc(OFS_CONTROL, 32'h16);
		if (brk) apb(OFS_CONTROL, 1'b1, 32'h12);
	endtask
	task prog(input logic [4:0] i, input logic [13:0] d, input logic wp);
		apb(OFS_CONTROL, 1'b1, 32'h02);
		setup(i, d);
		flash_wp <= wp;
		unlock(32'h03, 1'b0);
		if (wp) begin
			rdc(OFS_CONTROL, 32'h06);
			flash_wp <= 1'b0;
			apb(OFS_CONTROL, 1'b1, 32'h02);
			chk_row;
		end else begin
			lat[i] = d;
			foreach (lat[k]) efl[row][k] = cell_after(efl[row][k], lat[k]);
			rdc(OFS_CONTROL, 32'h03);
			finish_op(32'h02);
		end
	endtask
	initial begin
		void'($urandom(32'h3e979b1c));
		foreach (efl[r, c]) efl[r][c] = BLANK_WORD;
		foreach (lat[k]) lat[k] = BLANK_WORD;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		rdc(OFS_CONTROL, 32'h0);
		rdc(OFS_UNLOCK_KEY, 32'h0);
		apb(8'h1c, 1'b0, 32'h0);
		cmp(32'(er), 32'h1);
		apb(OFS_STATUS, 1'b1, 32'h2);
		r0 = 10'($urandom);
		for (int t = 0; t < 4; t++) begin
			row = (t % 2 == 0) ? r0 : 10'($urandom);
			load((t == 3) ? 31 : $urandom_range(0, 8), 1'b0);
			if (t == 1) load(1, 1'b1);
			prog(5'h1f - 5'(t), 14'($urandom), 1'b0);
		end
		row = r0;
		prog(5'h0, 14'h0, 1'b1);
		apb(OFS_CONTROL, 1'b1, 32'h42);
		unlock(32'h43, 1'b0);
		rdc(OFS_CONTROL, 32'h42);
		apb(OFS_CONTROL, 1'b1, 32'h00);
		unlock(32'h01, 1'b0);
		rdc(OFS_CONTROL, 32'h00);
		apb(OFS_CONTROL, 1'b1, 32'h0a);
		flash_wp <= 1'b1;
		unlock(32'h0b, 1'b0);
		rdc(OFS_CONTROL, 32'h0e);
		flash_wp <= 1'b0;
		chk_row;
		load(1, 1'b0);
		apb(OFS_CONTROL, 1'b1, 32'h0a);
		setup(5'h0, 14'h0);
		unlock(32'h0b, 1'b0);
		foreach (lat[k]) efl[row][k] = BLANK_WORD;
		finish_op(32'h0a);
		prog(5'h1f, 14'($urandom), 1'b0);
		end_of_test;
	end
endmodule
